/* File: hw/scc_cfg.svh */
// register offsets, field positions, reset values and timing counts
`ifndef SCC_CFG_SVH
`define SCC_CFG_SVH
`define SCC_SLOW_CFG_OFF      12'h000
`define SCC_MAIN_CTRL_OFF     12'h010
`define SCC_STATUS_OFF        12'h014
`define SCC_IRQ_MASK_OFF      12'h018
`define SCC_SLOW_CFG_RESET    32'h0000_0001
`define SCC_SLOW_CFG_MASK     32'h0000_000F
`define SCC_SC_RC_EN_BIT      0
`define SCC_SC_XT_EN_BIT      1
`define SCC_SC_XT_BYP_BIT     2
`define SCC_SC_SEL_BIT        3
`define SCC_MO_RC_EN_BIT      0
`define SCC_MO_XT_EN_BIT      1
`define SCC_MO_XT_BYP_BIT     2
`define SCC_MO_SEL_BIT        3
`define SCC_MO_CNT_LSB        8
`define SCC_MO_CNT_W          8
`define SCC_ST_XT_STABLE      0
`define SCC_ST_SW_DONE        1
`define SCC_ST_RC_STABLE      2
`define SCC_ST_SLOW_SEL       3
`define SCC_ST_W              4
`define SCC_DIV8              3'h7
`define SCC_SWITCH_CYCLES     3'h3
`define SCC_RC_SETTLE         3'h3
`endif

/* File: hw/scc_clock_source_ctrl.sv */
// slow and main clock source control with apb registers
//
// Added by the designer: the APB register port.
`include "scc_cfg.svh"
// How it works
// - slow config bit0 enables slow RC
// - slow config bit1 enables slow crystal
// - bit2 bypasses slow crystal for pin clock
// - bit3 selects slow source, 1 crystal
// - slow config resets to one
// - select write starts switch, status shows source
// - crystal select enables crystal, glitch-free switch
// - main RC disable clears its stable flag
// - main RC stable flag can interrupt
// - reset: crystal off, RC on and used
// - crystal disable clears crystal stable flag
// - startup count down on slow/8, then stable
// - main select glitch-free with done flag
// - main bypass uses external pin clock
// - reset: RC on, crystal off, select zero
module scc_clock_source_ctrl (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             irq,
	output logic             slow_rc_osc_enable,
	output logic             slow_crystal_enable,
	output logic             slow_crystal_bypass,
	output logic             slow_source_active,
	output logic             main_rc_enable,
	output logic             main_crystal_enable,
	output logic             main_crystal_bypass,
	output logic             main_source_active
);
	import scc_pkg::*;

	// register state and sequencer links
	logic [3:0]  slow_cfg_reg;
	logic [3:0]  main_ctrl_reg;
	scc_count_t  startup_reg;
	logic [2:0]  div_reg;
	logic [2:0]  rc_settle_reg;
	logic        xt_stable_reg;
	logic        rc_stable_reg;
	logic        slow_done_reg;
	logic        slow_switching;
	logic [`SCC_ST_W-1:0] events_reg;
	logic [`SCC_ST_W-1:0] mask_reg;
	logic [`SCC_ST_W-1:0] ev_set;
	logic        wr_en;
	logic        rd_en;
	logic        addr_ok;
	logic        wr_slow;
	logic        wr_main;
	logic        main_done_pulse;
	logic        main_switching;
	logic        slow_done_pulse;
	logic        xt_start;
	// decode and status helpers
	logic [3:0]  slow_cfg_next;
	logic [3:0]  main_ctrl_next;
	logic        apb_setup;
	logic        apb_access;
	logic        sel_slow;
	logic        sel_main;
	logic        sel_status;
	logic        sel_mask;
	logic        wr_status;
	logic        wr_mask;
	logic        xt_counting;
	logic        div_tick;
	logic        xt_rise;
	logic        rc_rise;
	logic        slow_done_next;
	logic        main_done;
	logic [`SCC_ST_W-1:0] clr_bits;
	logic [4:0]  live_bits;
	logic [31:0] status_word;
	logic [31:0] rd_word;

	// apb phases, zero wait states
	assign pready     = 1'b1;
	assign apb_setup  = psel && !penable;
	assign apb_access = psel && penable;

	// one select per mapped register
	assign sel_slow   = (paddr == `SCC_SLOW_CFG_OFF);
	assign sel_main   = (paddr == `SCC_MAIN_CTRL_OFF);
	assign sel_status = (paddr == `SCC_STATUS_OFF);
	assign sel_mask   = (paddr == `SCC_IRQ_MASK_OFF);
	assign addr_ok    = sel_slow || sel_main || sel_status || sel_mask;

	assign pslverr = apb_access && !addr_ok;

	// writes in access phase, reads sampled in setup phase
	assign wr_en   = apb_access && pwrite && addr_ok;
	assign rd_en   = apb_setup && !pwrite;

	// register write strobes
	assign wr_slow   = wr_en && sel_slow;
	assign wr_main   = wr_en && sel_main;
	assign wr_status = wr_en && sel_status;
	assign wr_mask   = wr_en && sel_mask;
	// write one to clear status events
	assign clr_bits  = wr_status ? pwdata[`SCC_ST_W-1:0] : {`SCC_ST_W{1'b0}};

	// next slow config value on a write
	always_comb begin
		slow_cfg_next = slow_cfg_reg;
		if (wr_slow) begin
			slow_cfg_next = pwdata[3:0];
			if (pwdata[`SCC_SC_SEL_BIT]) begin
				slow_cfg_next[`SCC_SC_XT_EN_BIT] = 1'b1;
			end
		end
	end

	// slow clock configuration register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slow_cfg_reg <= 4'(`SCC_SLOW_CFG_RESET);
		end else begin
			slow_cfg_reg <= slow_cfg_next;
		end
	end

	assign slow_rc_osc_enable  = slow_cfg_reg[`SCC_SC_RC_EN_BIT];
	assign slow_crystal_enable = slow_cfg_reg[`SCC_SC_XT_EN_BIT];
	// slow crystal bypass to pin clock
	assign slow_crystal_bypass = slow_cfg_reg[`SCC_SC_XT_BYP_BIT];

	scc_glitch_free_mux u_slow_mux (
		.pclk       (pclk),
		.presetn    (presetn),
		.sel_req    (slow_cfg_reg[`SCC_SC_SEL_BIT]),
		.sel_active (slow_source_active),
		.done_pulse (slow_done_pulse),
		.busy       (slow_switching)
	);

	// next main control value on a write
	always_comb begin
		main_ctrl_next = main_ctrl_reg;
		if (wr_main) begin
			main_ctrl_next = pwdata[3:0];
		end
	end

	// main oscillator control register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// RC on, crystal off, select RC
			main_ctrl_reg <= 4'h1;
		end else begin
			main_ctrl_reg <= main_ctrl_next;
		end
	end

	// main enables straight from the register
	assign main_rc_enable      = main_ctrl_reg[`SCC_MO_RC_EN_BIT];
	assign main_crystal_enable = main_ctrl_reg[`SCC_MO_XT_EN_BIT];
	// external clock on main crystal pin
	assign main_crystal_bypass = main_ctrl_reg[`SCC_MO_XT_BYP_BIT];

	scc_glitch_free_mux u_main_mux (
		.pclk       (pclk),
		.presetn    (presetn),
		.sel_req    (main_ctrl_reg[`SCC_MO_SEL_BIT]),
		.sel_active (main_source_active),
		.done_pulse (main_done_pulse),
		.busy       (main_switching)
	);

	// crystal enable written with a count starts the countdown
	assign xt_start    = wr_main && pwdata[`SCC_MO_XT_EN_BIT];
	// counting while the crystal is on and not yet stable
	assign xt_counting = main_crystal_enable && !xt_stable_reg && !xt_start;
	// one tick every eighth slow clock cycle
	assign div_tick    = (div_reg == 3'h0);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_reg <= 3'h0;
		end else if (xt_start) begin
			div_reg <= `SCC_DIV8;
		end else if (xt_counting) begin
			div_reg <= div_reg - 3'h1;
		end
	end

	// startup count, loaded on enable, down per tick
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			startup_reg <= 8'h00;
		end else if (xt_start) begin
			startup_reg <= pwdata[`SCC_MO_CNT_LSB +: `SCC_MO_CNT_W];
		end else if (!main_crystal_enable) begin
			startup_reg <= 8'h00;
		end else if (xt_counting && div_tick && startup_reg != 8'h00) begin
			startup_reg <= startup_reg - 8'h01;
		end
	end

	// disabled or restarted crystal is not stable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			xt_stable_reg <= 1'b0;
		end else if (xt_start || !main_crystal_enable) begin
			xt_stable_reg <= 1'b0;
		end else if (xt_counting && startup_reg == 8'h00) begin
			xt_stable_reg <= 1'b1;
		end
	end

	// main RC settle counter, restarts while RC is off
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rc_settle_reg <= `SCC_RC_SETTLE;
		end else if (!main_rc_enable) begin
			rc_settle_reg <= `SCC_RC_SETTLE;
		end else if (rc_settle_reg != 3'h0) begin
			rc_settle_reg <= rc_settle_reg - 3'h1;
		end
	end

	// main RC stable after a short settle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rc_stable_reg <= 1'b0;
		end else if (!main_rc_enable) begin
			rc_stable_reg <= 1'b0;
		end else if (rc_settle_reg == 3'h0) begin
			rc_stable_reg <= 1'b1;
		end
	end

	// slow done drops as soon as select and source differ
	assign slow_done_next = !slow_switching &&
			(slow_cfg_reg[`SCC_SC_SEL_BIT] == slow_source_active);

	// slow switch done level, registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slow_done_reg <= 1'b1;
		end else begin
			slow_done_reg <= slow_done_next;
		end
	end

	// main done: idle and on the requested source
	assign main_done = !main_switching &&
			(main_ctrl_reg[`SCC_MO_SEL_BIT] == main_source_active);

	// delayed crystal stable for edge detection
	logic xt_stable_d;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			xt_stable_d <= 1'b0;
		end else begin
			xt_stable_d <= xt_stable_reg;
		end
	end

	// delayed RC stable for edge detection
	logic rc_stable_d;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rc_stable_d <= 1'b0;
		end else begin
			rc_stable_d <= rc_stable_reg;
		end
	end

	// rising edges of the stable flags
	assign xt_rise = xt_stable_reg & ~xt_stable_d;
	assign rc_rise = rc_stable_reg & ~rc_stable_d;

	// event sources in status bit order
	assign ev_set = {slow_done_pulse, rc_rise, main_done_pulse, xt_rise};

	// one sticky event and mask bit per source
	for (genvar i = 0; i < `SCC_ST_W; i++) begin : g_event
		// write one clears, a set in the same cycle wins
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				events_reg[i] <= 1'b0;
			end else if (ev_set[i]) begin
				events_reg[i] <= 1'b1;
			end else if (clr_bits[i]) begin
				events_reg[i] <= 1'b0;
			end
		end

		// interrupt mask bit
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				mask_reg[i] <= 1'b0;
			end else if (wr_mask) begin
				mask_reg[i] <= pwdata[i];
			end
		end
	end

	// level interrupt while an unmasked event stands
	assign irq = |(events_reg & mask_reg);

	// live status bits above the sticky events
	assign live_bits[0] = xt_stable_reg;      // crystal stable
	assign live_bits[1] = main_done;          // main switch done
	assign live_bits[2] = rc_stable_reg;      // main RC stable
	assign live_bits[3] = slow_source_active; // slow source
	assign live_bits[4] = slow_done_reg;      // slow switch done
	assign status_word  = {23'h0, live_bits, events_reg};

	// read word of the addressed register
	always_comb begin
		rd_word = 32'h0000_0000;
		if (sel_slow) begin
			rd_word = {28'h0, slow_cfg_reg};
		end else if (sel_main) begin
			rd_word = {16'h0, startup_reg, 4'h0, main_ctrl_reg};
		end else if (sel_status) begin
			rd_word = status_word;
		end else if (sel_mask) begin
			rd_word = {28'h0, mask_reg};
		end
	end

	// read data registered in setup phase, held through access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (rd_en) begin
			prdata <= rd_word;
		end
	end
endmodule

/* File: hw/scc_glitch_free_mux.sv */
// glitch-free source switch sequencer: gate old source, wait, open new one
`include "scc_cfg.svh"
module scc_glitch_free_mux (
	input  wire logic            pclk,
	input  wire logic            presetn,
	input  wire logic            sel_req,
	output logic                 sel_active,
	output logic                 done_pulse,
	output logic                 busy
);
	import scc_pkg::*;
	scc_sw_e    state_reg;
	logic [2:0] wait_reg;

	// gate off, hold for a few cycles, then take the new source
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg  <= SCC_SW_IDLE;
			wait_reg   <= 3'h0;
			sel_active <= 1'b0;
			done_pulse <= 1'b0;
		end else begin
			done_pulse <= 1'b0;
			unique case (state_reg)
				SCC_SW_IDLE: begin
					if (sel_req != sel_active) begin
						state_reg <= SCC_SW_GATE;
						wait_reg  <= `SCC_SWITCH_CYCLES;
					end
				end
				SCC_SW_GATE: begin
					if (wait_reg == 3'h0) begin
						sel_active <= sel_req;
						state_reg  <= SCC_SW_OPEN;
						wait_reg   <= `SCC_SWITCH_CYCLES;
					end else begin
						wait_reg <= wait_reg - 3'h1;
					end
				end
				SCC_SW_OPEN: begin
					if (wait_reg == 3'h0) begin
						state_reg  <= SCC_SW_IDLE;
						done_pulse <= 1'b1;
					end else begin
						wait_reg <= wait_reg - 3'h1;
					end
				end
			endcase
		end
	end

	// busy whenever the sequencer is not idle
	assign busy = (state_reg != SCC_SW_IDLE);
endmodule

/* File: hw/scc_pkg.sv */
// types shared by the clock source control design
package scc_pkg;
	typedef enum logic [1:0] {SCC_SW_IDLE, SCC_SW_GATE, SCC_SW_OPEN} scc_sw_e;
	typedef logic [7:0] scc_count_t;
endpackage

/* File: tb/scc_csc_sva.sv */
// port assertions for the clock source control block
module scc_csc_sva (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        irq,
	input wire logic        slow_rc_osc_enable,
	input wire logic        slow_crystal_enable,
	input wire logic        slow_crystal_bypass,
	input wire logic        slow_source_active,
	input wire logic        main_rc_enable,
	input wire logic        main_crystal_enable,
	input wire logic        main_crystal_bypass,
	input wire logic        main_source_active
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// decoded accesses
	wire logic acc = psel && penable;
	wire logic ws  = acc && pwrite && paddr == 12'h000;
	wire logic wm  = acc && pwrite && paddr == 12'h010;
	wire logic um  = paddr != 12'h000 && paddr != 12'h010 && paddr != 12'h014
		&& paddr != 12'h018;
	slow_rc_a: assert property (ws |=> slow_rc_osc_enable == $past(pwdata[0]))
		else $error("slow rc enable wrong");
	slow_xt_a: assert property (ws |=> slow_crystal_enable == $past(pwdata[1] | pwdata[3]))
		else $error("slow crystal enable wrong");
	slow_byp_a: assert property (ws |=> slow_crystal_bypass == $past(pwdata[2]))
		else $error("slow bypass wrong");
	slow_glitch_a: assert property (ws && pwdata[3] != slow_source_active
		|=> $stable(slow_source_active) [*2]) else $error("slow source switched at once");
	main_rc_a: assert property (wm |=> main_rc_enable == $past(pwdata[0]))
		else $error("main rc enable wrong");
	main_xt_a: assert property (wm |=> main_crystal_enable == $past(pwdata[1]))
		else $error("main crystal enable wrong");
	main_byp_a: assert property (wm |=> main_crystal_bypass == $past(pwdata[2]))
		else $error("main bypass wrong");
	bus_err_a: assert property (acc |-> pslverr == um && pready)
		else $error("slave error or ready wrong");
	irq_mask_a: assert property (acc && pwrite && paddr == 12'h018 && pwdata[3:0] == 4'h0
		|=> !irq) else $error("masked interrupt seen");
	cover property (ws && pwdata[3]);
	cover property ($rose(main_source_active));
	cover property ($rose(irq));
endmodule

bind scc_clock_source_ctrl scc_csc_sva u_sva (.*);

/* File: tb/tb_scc_clock_source_ctrl.sv */
// self-checking bench for the clock source control block
module tb_scc_clock_source_ctrl;
	timeunit 1ns;
	timeprecision 1ns;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, d, e;
	logic        pready, pslverr, irq, err;
	logic        slow_rc_osc_enable, slow_crystal_enable, slow_crystal_bypass;
	logic        slow_source_active, main_rc_enable, main_crystal_enable;
	logic        main_crystal_bypass, main_source_active;
	int          n_errors = 0, cmp_count = 0, seed = 31, cyc = 0, c0;

	scc_clock_source_ctrl u_dut (.*);

	// clock and hang guard
	always #20 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 6000) begin
			n_errors++;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		if (n_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(string n, logic [31:0] s, logic [31:0] x);
		cmp_count++;
		if (s !== x) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", n, x, s);
		end
	endtask

	// one apb transfer, held until pready at an edge
	task automatic xfer(logic w, logic [11:0] a, logic [31:0] v);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		d = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(negedge pclk);
	endtask

	// poll a status bit, bounded
	task automatic wait_st(int b, logic v);
		for (int i = 0; i < 40; i++) begin
			xfer(1'b0, 12'h014, 32'h0);
			if (d[b] === v) return;
		end
		chk("status poll", {31'h0, d[b]}, {31'h0, v});
	endtask

	// readback of slow config: four bits, select forces crystal on
	function automatic logic [31:0] slow_exp(logic [31:0] v);
		return (v & 32'h0000_000F) | (v[3] ? 32'h0000_0002 : 32'h0);
	endfunction

	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		xfer(1'b0, 12'h000, 32'h0);
		chk("slow cfg reset", d, 32'h0000_0001);
		xfer(1'b0, 12'h010, 32'h0);
		chk("main ctrl reset", d & 32'h0000_000F, 32'h0000_0001);
		chk("main source", {31'h0, main_source_active}, 32'h0);
		for (int i = 0; i < 8; i++) begin
			e = (i == 0) ? 32'hFFFF_FFF0 : $random(seed) & 32'hFFFF_FFF7;
			xfer(1'b1, 12'h000, e);
			xfer(1'b0, 12'h000, 32'h0);
			chk("slow cfg", d, slow_exp(e));
			chk("slow pins", {29'h0, slow_crystal_bypass, slow_crystal_enable,
				slow_rc_osc_enable}, e & 32'h7);
		end
		// bypass first, then select crystal
		xfer(1'b1, 12'h000, 32'h0000_0005);
		xfer(1'b1, 12'h000, 32'h0000_000D);
		chk("slow xt forced", {31'h0, slow_crystal_enable}, 32'h1);
		wait_st(8, 1'b1);
		chk("slow source", {31'h0, slow_source_active}, 32'h1);
		xfer(1'b1, 12'h000, 32'h0000_0003);
		wait_st(8, 1'b1);
		chk("slow source back", {31'h0, slow_source_active}, 32'h0);
		repeat (5) @(posedge pclk);
		xfer(1'b1, 12'h000, 32'h0000_0001);
		// crystal startup of three counts
		xfer(1'b1, 12'h018, 32'h0000_0001);
		xfer(1'b1, 12'h010, 32'h0000_0303);
		c0 = cyc;
		xfer(1'b0, 12'h014, 32'h0);
		chk("xt stable early", d & 32'h10, 32'h0);
		wait_st(4, 1'b1);
		chk("startup time", {31'h0, cyc - c0 >= 24}, 32'h1);
		chk("xt irq", {31'h0, irq}, 32'h1);
		xfer(1'b1, 12'h014, 32'h0000_0001);
		chk("xt irq clear", {31'h0, irq}, 32'h0);
		xfer(1'b1, 12'h010, 32'h0000_0001);
		xfer(1'b0, 12'h014, 32'h0);
		chk("xt stable off", d & 32'h10, 32'h0);
		// main rc off then back on
		xfer(1'b1, 12'h018, 32'h0000_0004);
		xfer(1'b1, 12'h010, 32'h0);
		xfer(1'b0, 12'h014, 32'h0);
		chk("rc stable off", d & 32'h40, 32'h0);
		xfer(1'b1, 12'h014, 32'h0000_000F);
		xfer(1'b1, 12'h010, 32'h0000_0001);
		wait_st(6, 1'b1);
		chk("rc irq", {31'h0, irq}, 32'h1);
		xfer(1'b1, 12'h014, 32'h0000_0004);
		// main select with bypass
		xfer(1'b1, 12'h018, 32'h0000_0002);
		xfer(1'b1, 12'h010, 32'h0000_0003);
		xfer(1'b1, 12'h010, 32'h0000_0007);
		xfer(1'b1, 12'h010, 32'h0000_000D);
		chk("main bypass", {31'h0, main_crystal_bypass}, 32'h1);
		wait_st(5, 1'b1);
		chk("main source", {31'h0, main_source_active}, 32'h1);
		chk("main irq", {31'h0, irq}, 32'h1);
		xfer(1'b1, 12'h018, 32'h0);
		chk("irq masked", {31'h0, irq}, 32'h0);
		// unmapped place
		xfer(1'b1, 12'h020, 32'hFFFF_FFFF);
		chk("slverr", {31'h0, err}, 32'h1);
		xfer(1'b0, 12'h020, 32'h0);
		chk("unmapped read", d, 32'h0);
		report_and_stop();
	end
endmodule
